// ==== dfs_top.v ====
// What this block does
// - Fan1 hold bit keeps minimum duty below start-hyst
// - Too-low start temperature is raised
// - Target exceeded lowers the start temperature
// - Three 8-bit target registers, one degree per count
// - Target registers reset to 100 degrees code
// - Below low limit allows start increase
// - Below low limit raises an alarm
// - Above high limit raises an alarm; start not lowered by it
// - Six limit registers, low 0x01, high 0x7F
// - Short cycle every n, long every 2n
// - Remote1 and local codes in second control
// - Remote2 code split across both control registers
// - Code 000 is 8/16, doubling to 1024/2048
// - Between low limit and target-hyst, no change
// - Short cycle lowers start by twice the rise
// - Rise of a quarter degree gives no reduction
// - Long cycle idle between target-hyst and target
// - Above target, each long cycle lowers one degree
// - Long cycle raise needs all four conditions
// - Start temperature never raised above high limit
// - No adjustment while temperature below start
// - Per-channel enables in first control bits 7:5
// - Floor is -127 or -64 by format
// - Hysteresis nibbles per channel in two registers
`timescale 1ns/10ps
module dfs_top (
   input wire clk, // System clock, 125 MHz
   input wire srst, // Synchronous reset, active high
   input wire monTick, // One-cycle pulse per monitoring cycle
   input wire [9:0] remote1Temp, // Remote 1 reading, 2 fraction bits
   input wire [9:0] localTemp, // Local reading, 2 fraction bits
   input wire [9:0] remote2Temp, // Remote 2 reading, 2 fraction bits
   input wire [7:0] address, // Avalon word address (register index)
   input wire read, // Avalon read
   input wire write, // Avalon write
   input wire [31:0] writedata, // Avalon write data
   input wire [3:0] byteenable, // Avalon byte enables
   output reg [31:0] readdata_r, // Avalon read data
   output reg waitrequest_r, // Avalon wait request
   output reg [2:0] lowAlarm_r, // Level: temperature below low limit
   output reg [2:0] highAlarm_r, // Level: temperature above high limit
   output reg fan1HoldMin_r, // Level: hold fan 1 at minimum duty
   output reg fan1Off_r, // Level: fan 1 off
   output reg [23:0] startTemp_r // Start temperatures, remote 1 in bits 7:0, local 15:8, remote 2 23:16
);
`include "dfs_map.vh"
   reg [7:0] target_r [0:2];
   reg [7:0] lowLim_r [0:2];
   reg [7:0] highLim_r [0:2];
   reg [7:0] start_r [0:2];
   reg [7:0] cycOne_r;
   reg [7:0] cycTwo_r;
   reg [7:0] hystA_r;
   reg [7:0] hystB_r;
   reg [7:0] fanHold_r;
   reg [7:0] config_r;
   reg [7:0] status_r;
   reg [7:0] rdByte;
   wire access;
   wire wrEn;
   wire [7:0] wrByte;
   wire offset64;
   wire [7:0] minKey;
   wire [9:0] tempArr [0:2];
   wire [2:0] codeArr [0:2];
   wire [3:0] hystArr [0:2];
   wire [2:0] enArr;
   wire [2:0] shortEv;
   wire [2:0] longEv;
   wire [7:0] nextKey [0:2];
   wire [9:0] tempKey [0:2];
   wire [2:0] belowLow;
   wire [2:0] aboveHigh;
   wire [9:0] r1HoldEdge;

   assign access = (read || write) && waitrequest_r;
   // A write lands on the edge where the master sees waitrequest low
   assign wrEn = write && !waitrequest_r && byteenable[0];
   assign wrByte = writedata[7:0];
   assign offset64 = config_r[`DFS_BIT_OFFSET64];
   assign minKey = offset64 ? `DFS_MIN_KEY_OFS : `DFS_MIN_KEY_TWOS;

   assign tempArr[0] = remote1Temp;
   assign tempArr[1] = localTemp;
   assign tempArr[2] = remote2Temp;
   assign codeArr[0] = cycTwo_r[2:0];
   assign codeArr[1] = cycTwo_r[5:3];
   assign codeArr[2] = {cycTwo_r[7:6], cycOne_r[`DFS_BIT_R2_CODE_LSB]};
   assign hystArr[0] = hystA_r[7:4];
   assign hystArr[1] = hystA_r[3:0];
   assign hystArr[2] = hystB_r[7:4];
   assign enArr = {cycOne_r[`DFS_BIT_EN_R2], cycOne_r[`DFS_BIT_EN_LO],
      cycOne_r[`DFS_BIT_EN_R1]};

   // Offset-64 codes order as unsigned; two's complement needs the sign flip
   function [7:0] toKey;
      input [7:0] code;
      input ofs;
      begin
         toKey = ofs ? code : (code ^ 8'h80);
      end
   endfunction

   genvar ch;
   generate
      for (ch = 0; ch < 3; ch = ch + 1) begin : gChan
         assign tempKey[ch] = {toKey(tempArr[ch][9:2], offset64),
            tempArr[ch][1:0]};
         assign belowLow[ch] = tempKey[ch]
            < {toKey(lowLim_r[ch], offset64), 2'b00};
         assign aboveHigh[ch] = tempKey[ch]
            > {toKey(highLim_r[ch], offset64), 2'b00};

         dfs_cycle_timer #(
            .CNT_W(`DFS_CNT_W)
         ) uTimer (
            .clk(clk),
            .srst(srst),
            .monTick(monTick),
            .cycleCode(codeArr[ch]),
            .shortEv_r(shortEv[ch]),
            .longEv_r(longEv[ch])
         );

         dfs_channel uChan (
            .clk(clk),
            .srst(srst),
            .monTick(monTick),
            .tempKey(tempKey[ch]),
            .startKey(toKey(start_r[ch], offset64)),
            .targetKey(toKey(target_r[ch], offset64)),
            .hyst(hystArr[ch]),
            .lowKey(toKey(lowLim_r[ch], offset64)),
            .highKey(toKey(highLim_r[ch], offset64)),
            .minKey(minKey),
            .shortEv(shortEv[ch]),
            .longEv(longEv[ch]),
            .nextKey(nextKey[ch])
         );

         always @(posedge clk) begin
            if (srst) begin
               start_r[ch] <= `DFS_RST_START;
            end else if (wrEn && address == `DFS_ADDR_R1_START
                  + ch[7:0]) begin
               // Software write takes the start value over any update
               start_r[ch] <= wrByte;
            end else if (enArr[ch] && (shortEv[ch] || longEv[ch])
                  && tempKey[ch]
                  >= {toKey(start_r[ch], offset64), 2'b00}) begin
               start_r[ch] <= toKey(nextKey[ch], offset64);
            end
         end

         always @(posedge clk) begin
            if (srst) begin
               target_r[ch] <= `DFS_RST_TARGET;
               lowLim_r[ch] <= `DFS_RST_LOW;
               highLim_r[ch] <= `DFS_RST_HIGH;
            end else if (wrEn) begin
               if (address == `DFS_ADDR_R1_TARGET + ch[7:0]) begin
                  target_r[ch] <= wrByte;
               end
               if (address == `DFS_ADDR_R1_LOW + 2 * ch[7:0]) begin
                  lowLim_r[ch] <= wrByte;
               end
               if (address == `DFS_ADDR_R1_HIGH + 2 * ch[7:0]) begin
                  highLim_r[ch] <= wrByte;
               end
            end
         end
      end
   endgenerate

   // Control and configuration registers
   always @(posedge clk) begin
      if (srst) begin
         cycOne_r <= `DFS_RST_CYC;
         cycTwo_r <= `DFS_RST_CYC;
         hystA_r <= `DFS_RST_HYST_A;
         hystB_r <= `DFS_RST_HYST_B;
         fanHold_r <= 8'h00;
         config_r <= 8'h00;
      end else if (wrEn) begin
         case (address)
            `DFS_ADDR_CYC_ONE: begin
               cycOne_r <= wrByte;
            end
            `DFS_ADDR_CYC_TWO: begin
               cycTwo_r <= wrByte;
            end
            `DFS_ADDR_HYST_A: begin
               hystA_r <= wrByte;
            end
            `DFS_ADDR_HYST_B: begin
               hystB_r <= {wrByte[7:4], 4'h0};
            end
            `DFS_ADDR_FAN_HOLD: begin
               fanHold_r <= {2'b00, wrByte[`DFS_BIT_FAN1_HOLD], 5'h00};
            end
            `DFS_ADDR_CONFIG: begin
               config_r <= {7'h00, wrByte[`DFS_BIT_OFFSET64]};
            end
            default: begin
               cycOne_r <= cycOne_r;
            end
         endcase
      end
   end

   // Sticky alarm status: bits 2:0 below low, 5:3 above high.
   // A new event in the clearing cycle survives the write-one clear.
   always @(posedge clk) begin
      if (srst) begin
         status_r <= 8'h00;
         lowAlarm_r <= 3'b000;
         highAlarm_r <= 3'b000;
      end else begin
         lowAlarm_r <= belowLow;
         highAlarm_r <= aboveHigh;
         if (wrEn && address == `DFS_ADDR_STATUS) begin
            status_r <= (status_r & ~{2'b00, wrByte[5:0]})
               | {2'b00, aboveHigh, belowLow};
         end else begin
            status_r <= status_r | {2'b00, aboveHigh, belowLow};
         end
      end
   end

   // Fan 1 follows Remote 1: below start minus hysteresis
   assign r1HoldEdge = {toKey(start_r[0], offset64), 2'b00}
      - {4'h0, hystArr[0], 2'b00};
   always @(posedge clk) begin
      if (srst) begin
         fan1HoldMin_r <= 1'b0;
         fan1Off_r <= 1'b0;
         startTemp_r <= {3{`DFS_RST_START}};
      end else begin
         fan1HoldMin_r <= fanHold_r[`DFS_BIT_FAN1_HOLD]
            && tempKey[0] < r1HoldEdge;
         fan1Off_r <= !fanHold_r[`DFS_BIT_FAN1_HOLD]
            && tempKey[0] < r1HoldEdge;
         startTemp_r <= {start_r[2], start_r[1], start_r[0]};
      end
   end

   // Read mux; unmapped indices read as zero
   always @* begin
      case (address)
         `DFS_ADDR_R1_TARGET: rdByte = target_r[0];
         `DFS_ADDR_LO_TARGET: rdByte = target_r[1];
         `DFS_ADDR_R2_TARGET: rdByte = target_r[2];
         `DFS_ADDR_CYC_ONE: rdByte = cycOne_r;
         `DFS_ADDR_CYC_TWO: rdByte = cycTwo_r;
         `DFS_ADDR_STATUS: rdByte = status_r;
         `DFS_ADDR_R1_LOW: rdByte = lowLim_r[0];
         `DFS_ADDR_R1_HIGH: rdByte = highLim_r[0];
         `DFS_ADDR_LO_LOW: rdByte = lowLim_r[1];
         `DFS_ADDR_LO_HIGH: rdByte = highLim_r[1];
         `DFS_ADDR_R2_LOW: rdByte = lowLim_r[2];
         `DFS_ADDR_R2_HIGH: rdByte = highLim_r[2];
         `DFS_ADDR_FAN_HOLD: rdByte = fanHold_r;
         `DFS_ADDR_R1_START: rdByte = start_r[0];
         `DFS_ADDR_LO_START: rdByte = start_r[1];
         `DFS_ADDR_R2_START: rdByte = start_r[2];
         `DFS_ADDR_HYST_A: rdByte = hystA_r;
         `DFS_ADDR_HYST_B: rdByte = hystB_r;
         `DFS_ADDR_CONFIG: rdByte = config_r;
         default: rdByte = 8'h00;
      endcase
   end

   // Fixed one wait cycle: waitrequest drops on the edge after the request
   always @(posedge clk) begin
      if (srst) begin
         waitrequest_r <= 1'b1;
         readdata_r <= 32'h00000000;
      end else if (access) begin
         waitrequest_r <= 1'b0;
         readdata_r <= {24'h000000, rdByte};
      end else begin
         waitrequest_r <= 1'b1;
      end
   end
endmodule

// ==== dfs_map.vh ====
// Register map, field positions, reset values and timing for dynamic start temp
`ifndef DFS_MAP_VH
`define DFS_MAP_VH
`define DFS_ADDR_R1_TARGET 8'h33
`define DFS_ADDR_LO_TARGET 8'h34
`define DFS_ADDR_R2_TARGET 8'h35
`define DFS_ADDR_CYC_ONE 8'h36
`define DFS_ADDR_CYC_TWO 8'h37
`define DFS_ADDR_STATUS 8'h41
`define DFS_ADDR_R1_LOW 8'h4E
`define DFS_ADDR_R1_HIGH 8'h4F
`define DFS_ADDR_LO_LOW 8'h50
`define DFS_ADDR_LO_HIGH 8'h51
`define DFS_ADDR_R2_LOW 8'h52
`define DFS_ADDR_R2_HIGH 8'h53
`define DFS_ADDR_FAN_HOLD 8'h62
`define DFS_ADDR_R1_START 8'h67
`define DFS_ADDR_LO_START 8'h68
`define DFS_ADDR_R2_START 8'h69
`define DFS_ADDR_HYST_A 8'h6D
`define DFS_ADDR_HYST_B 8'h6E
`define DFS_ADDR_CONFIG 8'h7C
`define DFS_RST_TARGET 8'hA4
`define DFS_RST_LOW 8'h01
`define DFS_RST_HIGH 8'h7F
`define DFS_RST_HYST_A 8'h44
`define DFS_RST_HYST_B 8'h40
`define DFS_RST_START 8'h9A
`define DFS_RST_CYC 8'h00
`define DFS_BIT_FAN1_HOLD 5
`define DFS_BIT_R2_CODE_LSB 0
`define DFS_BIT_EN_R1 7
`define DFS_BIT_EN_LO 6
`define DFS_BIT_EN_R2 5
`define DFS_BIT_OFFSET64 0
`define DFS_SHORT_BASE_LOG2 3
`define DFS_CNT_W 11
`define DFS_MIN_KEY_TWOS 8'h01
`define DFS_MIN_KEY_OFS 8'h00
`endif

// ==== dfs_cycle_timer.v ====
// Short and long adjustment cycle strobes derived from the monitoring tick
`timescale 1ns/10ps
module dfs_cycle_timer #(
   parameter CNT_W = 11
) (
   input wire clk, // System clock
   input wire srst, // Synchronous reset, active high
   input wire monTick, // One pulse per monitoring cycle
   input wire [2:0] cycleCode, // Short cycle is 8 << code ticks
   output reg shortEv_r, // Pulse: short cycle due
   output reg longEv_r // Pulse: long cycle due
);
`include "dfs_map.vh"
   reg [CNT_W-1:0] count_r;
   wire [CNT_W-1:0] countInc;
   wire [CNT_W-1:0] shortMask;
   wire [CNT_W-1:0] longMask;

   assign countInc = count_r + {{(CNT_W-1){1'b0}}, 1'b1};
   // Period minus one as a mask: 8, 16 ... 1024 ticks
   // Shift amount is four bits wide so codes 5 to 7 do not wrap to zero
   assign shortMask = ({{(CNT_W-1){1'b0}}, 1'b1}
      << ({1'b0, cycleCode} + 4'd`DFS_SHORT_BASE_LOG2))
      - {{(CNT_W-1){1'b0}}, 1'b1};
   assign longMask = {shortMask[CNT_W-2:0], 1'b1};

   always @(posedge clk) begin
      if (srst) begin
         count_r <= {CNT_W{1'b0}};
         shortEv_r <= 1'b0;
         longEv_r <= 1'b0;
      end else begin
         shortEv_r <= monTick && ((countInc & shortMask) == 0);
         longEv_r <= monTick && ((countInc & longMask) == 0);
         if (monTick) begin
            count_r <= countInc;
         end
      end
   end
endmodule

// ==== dfs_channel.v ====
// One channel's start temperature update, computed in an ordered key domain
`timescale 1ns/10ps
module dfs_channel (
   input wire clk, // System clock
   input wire srst, // Synchronous reset, active high
   input wire monTick, // One pulse per monitoring cycle
   input wire [9:0] tempKey, // Temperature key, two fraction bits
   input wire [7:0] startKey, // Current start temperature key
   input wire [7:0] targetKey, // Target temperature key
   input wire [3:0] hyst, // Hysteresis in degrees
   input wire [7:0] lowKey, // Low limit key
   input wire [7:0] highKey, // High limit key
   input wire [7:0] minKey, // Lowest start temperature key
   input wire shortEv, // Short cycle strobe
   input wire longEv, // Long cycle strobe
   output wire [7:0] nextKey // Start temperature after this update
);
   reg [9:0] prevTemp_r;
   reg [9:0] rise_r;
   wire [9:0] rise;
   wire [9:0] opLessHyst;
   wire [9:0] shortRed;
   wire [10:0] lowered;
   wire [10:0] floorKey;
   wire [7:0] floored;
   wire raise;

   // Rise is latched at the tick: the strobe comes a cycle later, when
   // prevTemp_r already holds the new reading and would show no rise
   always @(posedge clk) begin
      if (srst) begin
         prevTemp_r <= 10'h000;
         rise_r <= 10'h000;
      end else if (monTick) begin
         prevTemp_r <= tempKey;
         rise_r <= rise;
      end
   end

   assign rise = (tempKey > prevTemp_r) ? tempKey - prevTemp_r : 10'h000;
   assign opLessHyst = {targetKey, 2'b00} - {4'h0, hyst, 2'b00};
   // Twice the rise in quarters is rise/2 degrees; a single quarter gives 0
   assign shortRed = (shortEv && tempKey > opLessHyst && rise_r > 10'h001)
      ? {1'b0, rise_r[9:1]} : 10'h000;
   assign lowered = {3'b000, startKey}
      - {1'b0, shortRed}
      - {10'h000, longEv && tempKey > {targetKey, 2'b00}};
   assign raise = longEv && tempKey < {lowKey, 2'b00}
      && tempKey > {startKey, 2'b00}
      && startKey < highKey && startKey < targetKey;
   // Signed compare guards against wrap below the floor
   assign floorKey = {3'b000, minKey};
   assign floored = ($signed(lowered) < $signed(floorKey)) ? minKey
      : lowered[7:0];
   assign nextKey = raise ? (floored == highKey ? floored : floored + 8'h01)
      : (floored > highKey && floored != startKey ? highKey
      : floored);
endmodule

// ==== dfs_top_props.sv ====
// Port-level assertions for the dynamic start temperature block
`timescale 1ns/10ps
`include "dfs_map.vh"
module dfs_top_props (
   input wire clk, // System clock
   input wire srst, // Synchronous reset
   input wire monTick, // Monitoring tick
   input wire [9:0] remote1Temp, // Remote 1 reading
   input wire [9:0] localTemp, // Local reading
   input wire [9:0] remote2Temp, // Remote 2 reading
   input wire [7:0] address, // Register index
   input wire read, // Bus read
   input wire write, // Bus write
   input wire [31:0] writedata, // Bus write data
   input wire [3:0] byteenable, // Bus byte enables
   input wire [31:0] readdata_r, // Bus read data
   input wire waitrequest_r, // Bus wait
   input wire [2:0] lowAlarm_r, // Below low limit
   input wire [2:0] highAlarm_r, // Above high limit
   input wire fan1HoldMin_r, // Fan 1 at minimum
   input wire fan1Off_r, // Fan 1 off
   input wire [23:0] startTemp_r // Start temperatures
);
   // Shadows of targets (0..2) and limits (3..8), updated on completed writes
   reg [7:0] sh_r [0:8];
   reg fmtSh_r;
   reg holdSh_r;
   reg en1Sh_r;
   reg [2:0] lowNow;
   reg [2:0] highNow;
   reg [9:0] tk;
   integer j;
   integer k;
   wire wrDone = write && !waitrequest_r && byteenable[0];
   wire hit = (address >= `DFS_ADDR_R1_TARGET && address <= `DFS_ADDR_R2_TARGET)
      || (address >= `DFS_ADDR_R1_LOW && address <= `DFS_ADDR_R2_HIGH);
   wire [7:0] idx = (address < 8'h40) ? address - 8'h33 : address - 8'h4B;
   wire startWr = wrDone && address == `DFS_ADDR_R1_START;
   // Two's complement codes are ordered by flipping the sign bit
   wire [7:0] flip = {~fmtSh_r, 7'h00};
   wire [29:0] temps = {remote2Temp, localTemp, remote1Temp};
   wire [9:0] startKey = {startTemp_r[7:0] ^ flip, 2'b00};
   wire [9:0] r1Key = {remote1Temp[9:2] ^ flip, remote1Temp[1:0]};
   wire fracZero = temps[1:0] == 2'b00 && temps[11:10] == 2'b00
      && temps[21:20] == 2'b00;
   always @* begin
      for (j = 0; j < 3; j = j + 1) begin
         tk = {temps[10*j+2 +: 8] ^ flip, temps[10*j +: 2]};
         lowNow[j] = tk < {sh_r[3+2*j] ^ flip, 2'b00};
         highNow[j] = tk > {sh_r[4+2*j] ^ flip, 2'b00};
      end
   end
   always @(posedge clk) begin
      if (srst) begin
         for (k = 0; k < 9; k = k + 1)
            sh_r[k] <= (k < 3) ? `DFS_RST_TARGET
               : (k % 2 == 1) ? `DFS_RST_LOW : `DFS_RST_HIGH;
         fmtSh_r <= 1'b0;
         holdSh_r <= 1'b0;
         en1Sh_r <= 1'b0;
      end else if (wrDone) begin
         if (hit)
            sh_r[idx] <= writedata[7:0];
         if (address == `DFS_ADDR_CONFIG)
            fmtSh_r <= writedata[`DFS_BIT_OFFSET64];
         if (address == `DFS_ADDR_FAN_HOLD)
            holdSh_r <= writedata[`DFS_BIT_FAN1_HOLD];
         if (address == `DFS_ADDR_CYC_ONE)
            en1Sh_r <= writedata[`DFS_BIT_EN_R1];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence reqTaken;
      (read || write) && waitrequest_r;
   endsequence
   sequence answerPulse;
      !waitrequest_r ##1 waitrequest_r;
   endsequence
   // Start changes not caused by a software write to the remote 1 start
   sequence hwUpdate;
      !$past(srst) && $changed(startTemp_r[7:0]) && !$past(startWr, 2);
   endsequence
   a_bus_answer: assert property (reqTaken |=> answerPulse)
      else $error("bus request not answered after one cycle");
   a_read_back: assert property ((read && !waitrequest_r && hit)
      |-> readdata_r == {24'h000000, sh_r[idx]})
      else $error("register read data differs from last write");
   a_low_alarm: assert property (!$past(srst)
      |-> lowAlarm_r == $past(lowNow))
      else $error("low alarm does not follow temperature");
   a_high_alarm: assert property ((!$past(srst) && $past(fracZero))
      |-> highAlarm_r == $past(highNow))
      else $error("high alarm does not follow temperature");
   a_fan_select: assert property ((fan1HoldMin_r || fan1Off_r)
      |-> fan1HoldMin_r == $past(holdSh_r))
      else $error("fan 1 hold and off disagree with hold bit");
   a_start_timing: assert property (hwUpdate
      |-> $past(monTick, 3))
      else $error("start temperature moved off the tick schedule");
   a_start_gated: assert property (hwUpdate
      |-> $past(en1Sh_r, 2) && $past(r1Key, 2) >= $past(startKey))
      else $error("start adjusted while disabled or below start");
   a_start_ceiling: assert property (hwUpdate
      |-> (startTemp_r[7:0] ^ flip) <= (sh_r[4] ^ flip))
      else $error("start temperature above high limit");
endmodule
bind dfs_top dfs_top_props chk (
   .clk(clk), .srst(srst), .monTick(monTick),
   .remote1Temp(remote1Temp), .localTemp(localTemp),
   .remote2Temp(remote2Temp), .address(address), .read(read),
   .write(write), .writedata(writedata), .byteenable(byteenable),
   .readdata_r(readdata_r), .waitrequest_r(waitrequest_r),
   .lowAlarm_r(lowAlarm_r), .highAlarm_r(highAlarm_r),
   .fan1HoldMin_r(fan1HoldMin_r), .fan1Off_r(fan1Off_r),
   .startTemp_r(startTemp_r)
);

// ==== tb_top.sv ====
// Self-checking bench for the dynamic start temperature block
`timescale 1ns/10ps
`include "dfs_map.vh"
module tb_top;
   reg clk;
   reg srst;
   reg monTick;
   reg [9:0] remote1Temp;
   reg [9:0] localTemp;
   reg [9:0] remote2Temp;
   reg [7:0] address;
   reg read;
   reg write;
   reg [31:0] writedata;
   reg [3:0] byteenable;
   reg [31:0] rdWord;
   wire [31:0] readdata_r;
   wire waitrequest_r;
   wire [2:0] lowAlarm_r;
   wire [2:0] highAlarm_r;
   wire fan1HoldMin_r;
   wire fan1Off_r;
   wire [23:0] startTemp_r;
   integer miscompares;
   integer num_checks;
   integer gTick;
   dfs_top uut (.clk(clk), .srst(srst), .monTick(monTick),
      .remote1Temp(remote1Temp), .localTemp(localTemp),
      .remote2Temp(remote2Temp), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata_r(readdata_r), .waitrequest_r(waitrequest_r),
      .lowAlarm_r(lowAlarm_r), .highAlarm_r(highAlarm_r),
      .fan1HoldMin_r(fan1HoldMin_r), .fan1Off_r(fan1Off_r),
      .startTemp_r(startTemp_r));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task finish_test;
      begin
         $display("checks %0d miscompares %0d", num_checks, miscompares);
         if (miscompares == 0 && num_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task check(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Request held until waitrequest is sampled low; bounded wait
   task bus(input isRd, input [7:0] a, input [7:0] d);
      integer n;
      begin
         @(posedge clk);
         read <= isRd;
         write <= !isRd;
         address <= a;
         writedata <= {24'h000000, d};
         n = 0;
         do begin
            @(posedge clk);
            n = n + 1;
         end while (waitrequest_r !== 1'b0 && n < 20);
         rdWord = readdata_r;
         read <= 1'b0;
         write <= 1'b0;
         if (waitrequest_r !== 1'b0) begin
            miscompares = miscompares + 1;
            finish_test;
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      bus(1'b0, a, d);
   endtask
   task rdChk(input [7:0] a, input [7:0] e);
      begin
         bus(1'b1, a, 8'h00);
         check(rdWord, {24'h000000, e});
      end
   endtask
   task setTemps(input [7:0] t);
      begin
         remote1Temp <= {t, 2'b00};
         localTemp <= {t, 2'b00};
         remote2Temp <= {t, 2'b00};
      end
   endtask
   // Start updates land three edges after the tick; four are allowed
   task ticks(input integer n);
      integer i;
      for (i = 0; i < n; i = i + 1) begin
         @(posedge clk);
         monTick <= 1'b1;
         @(posedge clk);
         monTick <= 1'b0;
         repeat (4) @(posedge clk);
         gTick = gTick + 1;
      end
   endtask
   function [7:0] dec(input [7:0] b, input integer len);
      dec = b - gTick / len;
   endfunction
   task test_regs;
      integer i;
      integer j;
      reg [7:0] a;
      reg [7:0] e;
      begin
         for (j = 0; j < 2; j = j + 1) begin
            for (i = 0; i < 10; i = i + 1) begin
               a = (i < 3) ? 8'h33 + i[7:0] : (i < 9) ? 8'h4B + i[7:0] : 8'h00;
               e = (i < 3) ? `DFS_RST_TARGET : i[0] ? `DFS_RST_LOW : `DFS_RST_HIGH;
               e = (i == 9) ? 8'h00 : (j == 1) ? 8'h30 + i[7:0] : e;
               rdChk(a, e);
               if (j == 0)
                  wr(a, 8'h30 + i[7:0]);
            end
         end
         $display("test_regs done");
      end
   endtask
   task test_alarms;
      integer i;
      begin
         wr(`DFS_ADDR_CONFIG, 8'h01);
         for (i = 0; i < 3; i = i + 1) begin
            wr(8'h4E + 2 * i[7:0], 8'h50);
            wr(8'h4F + 2 * i[7:0], 8'h70);
         end
         for (i = 0; i < 3; i = i + 1) begin
            setTemps((i == 0) ? 8'h78 : (i == 1) ? 8'h60 : 8'h40);
            repeat (3) @(posedge clk);
            check(lowAlarm_r, (i == 2) ? 32'h7 : 32'h0);
            check(highAlarm_r, (i == 0) ? 32'h7 : 32'h0);
         end
         wr(`DFS_ADDR_FAN_HOLD, 8'h20);
         repeat (2) @(posedge clk);
         check({fan1HoldMin_r, fan1Off_r}, 32'h2);
         wr(`DFS_ADDR_FAN_HOLD, 8'h00);
         repeat (2) @(posedge clk);
         check({fan1HoldMin_r, fan1Off_r}, 32'h1);
         $display("test_alarms done");
      end
   endtask
   task test_cycles;
      integer i;
      begin
         for (i = 0; i < 3; i = i + 1) begin
            wr(8'h33 + i[7:0], 8'h60);
            wr(8'h4E + 2 * i[7:0], 8'h01);
            wr(8'h4F + 2 * i[7:0], 8'h7F);
            wr(8'h67 + i[7:0], 8'h50);
         end
         wr(`DFS_ADDR_CYC_TWO, 8'h10);
         wr(`DFS_ADDR_CYC_ONE, 8'hE1);
         setTemps(8'h70);
         for (i = 0; i < 64; i = i + 1) begin
            ticks(1);
            check(startTemp_r, {dec(8'h50, 32), dec(8'h50, 64), dec(8'h50, 16)});
         end
         $display("test_cycles done");
      end
   endtask
   task test_short;
      integer k;
      reg [7:0] e;
      reg [2:0] rise;
      begin
         e = 8'h4C;
         for (k = 65; k <= 96; k = k + 1) begin
            rise = (k % 8 != 0) ? 3'd0 : (k < 81) ? 3'd4 : 3'd1;
            remote1Temp <= remote1Temp + rise;
            ticks(1);
            e = e - ((rise == 3'd4) ? 8'h02 : 8'h00);
            e = e - ((k % 16 == 0) ? 8'h01 : 8'h00);
            check(startTemp_r[7:0], e);
         end
         $display("test_short done");
      end
   endtask
   // Each phase after the first would move the start if its gating rule were ignored
   task test_raise;
      integer p;
      begin
         wr(`DFS_ADDR_R1_START, 8'h50);
         wr(`DFS_ADDR_R1_TARGET, 8'h70);
         for (p = 0; p < 5; p = p + 1) begin
            wr(`DFS_ADDR_R1_HIGH, (p < 2) ? 8'h51 : 8'h7F);
            wr(`DFS_ADDR_R1_LOW, (p == 3) ? 8'h30 : 8'h60);
            wr(`DFS_ADDR_CYC_ONE, (p == 4) ? 8'h61 : 8'hE1);
            remote1Temp <= {(p == 2) ? 8'h40 : (p == 4) ? 8'h78 : 8'h58, 2'b00};
            ticks(16);
            check(startTemp_r[7:0], 8'h51);
         end
         $display("test_raise done");
      end
   endtask
   initial begin
      srst = 1'b1;
      monTick = 1'b0;
      remote1Temp = 10'h000;
      localTemp = 10'h000;
      remote2Temp = 10'h000;
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h00000000;
      byteenable = 4'hF;
      miscompares = 0;
      num_checks = 0;
      gTick = 0;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      test_regs;
      test_alarms;
      test_cycles;
      test_short;
      test_raise;
      finish_test;
   end
endmodule
